// ==== dsl_lock_fsm.sv ====
// Security mode state machine for the drive command layer
`timescale 1ns/1ps
module dsl_lock_fsm #(
  parameter logic [2:0] ATTEMPTS = dsl_pkg::ATTEMPT_LIMIT
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        power_on,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_opcode,
  input  wire logic        cmd_is_media,
  input  wire logic        cmd_is_lock_restricted,
  input  wire logic        pw_is_master,
  input  wire logic        pw_match,
  input  wire logic        set_max_level,
  input  wire logic [15:0] set_rev_code,
  output logic             cmd_done,
  output logic             cmd_aborted,
  output logic             cmd_execute,
  output logic             erase_user_data,
  output logic [1:0]       sec_mode,
  output logic             level_max,
  output logic             user_pw_set,
  output logic             lock_enabled,
  output logic [15:0]      master_rev_code,
  output logic             attempts_exhausted_flag,
  output logic [2:0]       fail_count
);
  // ----------------------------------------
  // Retained state
  // ----------------------------------------
  dsl_pkg::dsl_mode_e mode_reg;
  logic               first_cmd_reg;

  // ----------------------------------------
  // Decode and decision signals
  // ----------------------------------------
  logic               rev_ok;
  logic               refuse;
  logic               mode_refuse;
  logic               guard_refuse;
  logic               is_set_pw;
  logic               is_unlock;
  logic               is_erase_prep;
  logic               is_erase;
  logic               is_freeze;
  logic               is_disable_pw;
  logic               is_sec_change;
  logic               pw_ok;
  logic               pw_fail;
  logic               may_unlock;
  logic               do_cmd;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (ATTEMPTS == 3'h0) begin : g_bad_attempts
    $error("ATTEMPTS must be at least one");
  end

  // ----------------------------------------
  // Opcode decode
  // ----------------------------------------
  always_comb begin
    is_set_pw     = 1'b0;
    is_unlock     = 1'b0;
    is_erase_prep = 1'b0;
    is_erase      = 1'b0;
    is_freeze     = 1'b0;
    is_disable_pw = 1'b0;
    case (cmd_opcode)
      dsl_pkg::OP_SET_PW: begin
        is_set_pw = 1'b1;
      end
      dsl_pkg::OP_UNLOCK: begin
        is_unlock = 1'b1;
      end
      dsl_pkg::OP_ERASE_PREP: begin
        is_erase_prep = 1'b1;
      end
      dsl_pkg::OP_ERASE_UNIT: begin
        is_erase = 1'b1;
      end
      dsl_pkg::OP_FREEZE: begin
        is_freeze = 1'b1;
      end
      dsl_pkg::OP_DISABLE_PW: begin
        is_disable_pw = 1'b1;
      end
      default: begin
        is_set_pw = 1'b0;
      end
    endcase
  end

  // Every password or lock command except freeze lock
  assign is_sec_change = is_set_pw || is_unlock || is_erase_prep || is_erase
                      || is_disable_pw;

  // ----------------------------------------
  // Password checks
  // ----------------------------------------
  assign rev_ok = (set_rev_code >= dsl_pkg::REV_MIN) && (set_rev_code <= dsl_pkg::REV_MAX);
  assign pw_ok = pw_match && (pw_is_master || user_pw_set);
  // Master unlock alone only at high level; erase unit always allowed
  assign may_unlock = pw_ok && (!pw_is_master || !level_max || is_erase);
  // Matching master at maximum level is refused, yet no mismatch
  assign pw_fail = (is_unlock || is_erase) && !pw_match;

  // ----------------------------------------
  // Acceptance decision
  // ----------------------------------------
  always_comb begin
    mode_refuse = 1'b0;
    case (mode_reg)
      dsl_pkg::DSL_LOCKED: begin
        mode_refuse = cmd_is_media || cmd_is_lock_restricted || is_set_pw
                   || is_disable_pw || is_freeze;
      end
      dsl_pkg::DSL_FROZEN: begin
        mode_refuse = is_sec_change;
      end
      dsl_pkg::DSL_UNLOCKED: begin
        mode_refuse = 1'b0;
      end
      default: begin
        mode_refuse = 1'b1;
      end
    endcase
  end

  // Guards that hold in every mode
  always_comb begin
    guard_refuse = 1'b0;
    if ((is_unlock || is_erase) && attempts_exhausted_flag) begin
      guard_refuse = 1'b1;
    end
    // Bad password ends as an abort
    if ((is_unlock || is_erase || is_disable_pw) && !may_unlock) begin
      guard_refuse = 1'b1;
    end
    if (is_set_pw && pw_is_master && !rev_ok) begin
      guard_refuse = 1'b1;
    end
  end

  assign refuse = mode_refuse || guard_refuse;
  assign do_cmd = cmd_valid && !refuse;

  // ----------------------------------------
  // Command answer
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmd_done        <= 1'b0;
      cmd_aborted     <= 1'b0;
      cmd_execute     <= 1'b0;
      erase_user_data <= 1'b0;
    end else begin
      cmd_done        <= cmd_valid;
      cmd_aborted     <= cmd_valid && refuse;
      cmd_execute     <= do_cmd;
      erase_user_data <= do_cmd && is_erase;
    end
  end

  // ----------------------------------------
  // Mode: entered from lock enable after each reset
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      first_cmd_reg <= 1'b1;
      mode_reg      <= dsl_pkg::DSL_UNLOCKED;
    end else if (first_cmd_reg) begin
      first_cmd_reg <= 1'b0;
      mode_reg      <= lock_enabled ? dsl_pkg::DSL_LOCKED : dsl_pkg::DSL_UNLOCKED;
    end else if (do_cmd) begin
      case (mode_reg)
        dsl_pkg::DSL_LOCKED: begin
          if (is_unlock || is_erase) begin
            mode_reg <= dsl_pkg::DSL_UNLOCKED;
          end
        end
        dsl_pkg::DSL_UNLOCKED: begin
          if (cmd_opcode == dsl_pkg::OP_FREEZE) begin
            mode_reg <= dsl_pkg::DSL_FROZEN;
          end
        end
        dsl_pkg::DSL_FROZEN: begin
          mode_reg <= dsl_pkg::DSL_FROZEN;
        end
        default: begin
          mode_reg <= dsl_pkg::DSL_LOCKED;
        end
      endcase
    end
  end

  assign sec_mode = mode_reg;

  // ----------------------------------------
  // Passwords and level, loaded at power-on and kept over reset
  // ----------------------------------------
  // User password flag
  always_ff @(posedge clock) begin
    if (power_on) begin
      user_pw_set <= 1'b0;
    end else if (do_cmd && !first_cmd_reg) begin
      if (is_set_pw && !pw_is_master) begin
        user_pw_set <= 1'b1;
      end else if (is_disable_pw || is_erase) begin
        user_pw_set <= 1'b0;
      end
    end
  end

  // Lock function follows the user password only
  always_ff @(posedge clock) begin
    if (power_on) begin
      lock_enabled <= 1'b0;
    end else if (do_cmd && !first_cmd_reg) begin
      if (is_set_pw && !pw_is_master) begin
        lock_enabled <= 1'b1;
      end else if (is_disable_pw || is_erase) begin
        lock_enabled <= 1'b0;
      end
    end
  end

  // Security level, chosen with the user password
  always_ff @(posedge clock) begin
    if (power_on) begin
      level_max <= 1'b0;
    end else if (do_cmd && !first_cmd_reg) begin
      if (is_set_pw && !pw_is_master) begin
        level_max <= set_max_level;
      end else if (is_disable_pw || is_erase) begin
        level_max <= 1'b0;
      end
    end
  end

  // Master revision code; master set never touches the lock
  always_ff @(posedge clock) begin
    if (power_on) begin
      master_rev_code <= dsl_pkg::REV_FACTORY;
    end else if (do_cmd && !first_cmd_reg) begin
      if (is_set_pw && pw_is_master) begin
        master_rev_code <= set_rev_code;
      end
    end
  end

  // ----------------------------------------
  // Failed attempt counting
  // ----------------------------------------
  // Counter stops once the flag is up
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fail_count <= 3'h0;
    end else if (cmd_valid && pw_fail && !attempts_exhausted_flag
                 && mode_reg != dsl_pkg::DSL_FROZEN) begin
      fail_count <= fail_count + 3'h1;
    end
  end

  // Exhausted flag, raised with the last counted mismatch
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      attempts_exhausted_flag <= 1'b0;
    end else if (cmd_valid && pw_fail && !attempts_exhausted_flag
                 && mode_reg != dsl_pkg::DSL_FROZEN
                 && (fail_count + 3'h1) == ATTEMPTS) begin
      attempts_exhausted_flag <= 1'b1;
    end
  end
endmodule

// ==== dsl_pkg.sv ====
// Constants and types for the disk security lock state machine
// What this block does
// - Opcodes F1 set password, F2 unlock, F3 erase prepare are decoded.
// - Opcodes F4 erase unit, F5 freeze lock, F6 disable password are decoded.
// - With a user password set, enter locked at the first clock after reset and refuse media access.
// - Leave locked only on successful unlock or successful erase unit.
// - Without user password start unlocked; unlocked refuses only commands failing the password, revision or attempt-limit checks.
// - Freeze lock from unlocked enters frozen; lock-changing and password commands refused there.
// - Frozen holds until the next reset.
// - High level: correct master password also unlocks a locked device.
// - Maximum level: master unlocks only with erase unit, erasing user data.
// - Setting master password never enables lock, but master may unlock.
// - Master revision code kept, updated on change, valid 0001h to FFFEh.
// - Factory master revision code is FFFEh.
// - Setting user password enables lock; locking happens at next reset.
// - Five failed comparisons set exhausted flag; unlock and erase unit abort.
// - Failure count and exhausted flag cleared only by hard reset (rst); power_on alone leaves them.
package dsl_pkg;
  // ----------------------------------------
  // Command opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_SET_PW     = 8'hf1;
  localparam logic [7:0] OP_UNLOCK     = 8'hf2;
  localparam logic [7:0] OP_ERASE_PREP = 8'hf3;
  localparam logic [7:0] OP_ERASE_UNIT = 8'hf4;
  localparam logic [7:0] OP_FREEZE     = 8'hf5;
  localparam logic [7:0] OP_DISABLE_PW = 8'hf6;
  // ----------------------------------------
  // Identify fields and counts
  // ----------------------------------------
  localparam int          ID_WORD_REV       = 92;
  localparam int          ID_WORD_SEC       = 128;
  localparam int          ID_EXHAUSTED_BIT  = 4;
  localparam logic [15:0] REV_FACTORY       = 16'hfffe;
  localparam logic [15:0] REV_MIN           = 16'h0001;
  localparam logic [15:0] REV_MAX           = 16'hfffe;
  localparam logic [2:0]  ATTEMPT_LIMIT     = 3'h5;
  typedef enum logic [1:0] {
    DSL_UNLOCKED = 2'b00,
    DSL_LOCKED   = 2'b01,
    DSL_FROZEN   = 2'b10
  } dsl_mode_e;
endpackage

// ==== dsl_chk_props.sv ====
// Assertion checker for the security mode state machine
`timescale 1ns/1ps
module dsl_chk (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic       cmd_is_media,
  input wire logic       pw_is_master,
  input wire logic       cmd_done,
  input wire logic       cmd_aborted,
  input wire logic       cmd_execute,
  input wire logic       erase_user_data,
  input wire logic [1:0] sec_mode,
  input wire logic       level_max,
  input wire logic [2:0] fail_count,
  input wire logic       attempts_exhausted_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire unl = cmd_valid && cmd_opcode == 8'hf2;
  wire ers = cmd_valid && cmd_opcode == 8'hf4;
  property p_done; cmd_valid |=> cmd_done; endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_med; cmd_valid && cmd_is_media && sec_mode == 2'h1 |=> cmd_aborted; endproperty
  a_med: assert property (p_med) else $error("media ran locked");
  property p_keep; sec_mode == 2'h1 && !unl && !ers |=> sec_mode == 2'h1; endproperty
  a_keep: assert property (p_keep) else $error("left locked");
  property p_frz; sec_mode == 2'h2 |=> sec_mode == 2'h2; endproperty
  a_frz: assert property (p_frz) else $error("left frozen");
  property p_fz; cmd_valid && cmd_opcode == 8'hf5 && sec_mode == 2'h0 |=> sec_mode == 2'h2; endproperty
  a_fz: assert property (p_fz) else $error("no freeze");
  property p_fset; sec_mode == 2'h2 && cmd_valid && cmd_opcode == 8'hf1 |=> cmd_aborted; endproperty
  a_fset: assert property (p_fset) else $error("set in frozen");
  property p_exh; attempts_exhausted_flag && (unl || ers) |=> cmd_aborted; endproperty
  a_exh: assert property (p_exh) else $error("ran when exhausted");
  property p_max; level_max && sec_mode == 2'h1 && unl && pw_is_master |=> cmd_aborted; endproperty
  a_max: assert property (p_max) else $error("master unlock at max");
  property p_ers; erase_user_data |-> cmd_execute && $past(cmd_opcode) == 8'hf4; endproperty
  a_ers: assert property (p_ers) else $error("stray erase");
  property p_abx; cmd_aborted |-> cmd_done && !cmd_execute; endproperty
  a_abx: assert property (p_abx) else $error("abort not exclusive");
  property p_cnt; attempts_exhausted_flag == (fail_count == 3'h5); endproperty
  a_cnt: assert property (p_cnt) else $error("flag and count disagree");
endmodule

// ==== dsl_host_model.sv ====
// Host command driver for the security state machine
`timescale 1ns/1ps
module dsl_host_model (
  input  wire logic  clock,
  output logic       cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic       cmd_is_media,
  output logic       cmd_is_lock_restricted,
  output logic       pw_is_master,
  output logic       pw_match,
  output logic       set_max_level,
  output logic [15:0] set_rev_code
);
  initial begin
    {cmd_valid, cmd_opcode, set_rev_code} = '0;
    {cmd_is_media, cmd_is_lock_restricted, pw_is_master, pw_match, set_max_level} = '0;
  end
  task automatic issue(input logic [7:0] op, input logic [4:0] f, input logic [15:0] rev);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_opcode = op;
    {cmd_is_media, cmd_is_lock_restricted, pw_is_master, pw_match, set_max_level} = f;
    set_rev_code = rev;
    @(negedge clock);
    cmd_valid = 1'b0;
    // Idle fields no longer show the command
    cmd_opcode = ~op;
    {cmd_is_media, cmd_is_lock_restricted, pw_is_master, pw_match, set_max_level} = ~f;
    set_rev_code = ~rev;
  endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the security state machine
`timescale 1ns/1ps
module tb_top;
  logic clock, rst, power_on, cmd_valid, cmd_is_media, cmd_is_lock_restricted;
  logic pw_is_master, pw_match, set_max_level, cmd_done, cmd_aborted, cmd_execute;
  logic erase_user_data, level_max, user_pw_set, lock_enabled, attempts_exhausted_flag;
  logic [7:0]  cmd_opcode;
  logic [15:0] set_rev_code, master_rev_code, rv;
  logic [1:0]  sec_mode;
  logic [2:0]  fail_count;
  int          error_cnt = 0;
  int          n_compared = 0;
  localparam logic [4:0] MED = 5'h10, RES = 5'h08, MAS = 5'h04, OK = 5'h02, MOK = 5'h06;
  dsl_lock_fsm dut_u (.*);
  dsl_host_model host_u (.*);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic t(input logic [7:0] op, input logic [4:0] f, input logic ab, input logic [1:0] m);
    host_u.issue(op, f, rv);
    cmp(cmd_done, 1'b1);
    cmp(cmd_aborted, ab);
    cmp(cmd_execute, !ab);
    cmp(sec_mode, m);
  endtask
  task automatic rs(input logic po);
    $display("test done at %0t", $time);
    @(negedge clock);
    rst = 1'b1;
    power_on = po;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    power_on = 1'b0;
    @(negedge clock);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    complete_run;
  end
  initial begin
    {rst, power_on, rv} = '0;
    rs(1'b1);
    cmp(master_rev_code, 16'hfffe);
    t(8'h20, MED, 1'b0, 2'h0);
    t(8'hf1, MAS, 1'b1, 2'h0);
    rv = 16'h1234;
    t(8'hf1, MAS, 1'b0, 2'h0);
    cmp(master_rev_code, 16'h1234);
    cmp(lock_enabled, 1'b0);
    t(8'hf1, 5'h00, 1'b0, 2'h0);
    cmp(lock_enabled, 1'b1);
    cmp(user_pw_set, 1'b1);
    rs(1'b0);
    cmp(sec_mode, 2'h1);
    cmp(master_rev_code, 16'h1234);
    t(8'h20, MED, 1'b1, 2'h1);
    t(8'ha2, RES, 1'b1, 2'h1);
    t(8'hf1, 5'h00, 1'b1, 2'h1);
    t(8'hf6, OK, 1'b1, 2'h1);
    t(8'hf5, 5'h00, 1'b1, 2'h1);
    t(8'hf3, 5'h00, 1'b0, 2'h1);
    t(8'hf2, MOK, 1'b0, 2'h0);
    t(8'hf5, 5'h00, 1'b0, 2'h2);
    for (int i = 1; i < 7; i++) begin
      if (i != 5) t(8'hf0 + 8'(i), OK, 1'b1, 2'h2);
    end
    t(8'h20, MED, 1'b0, 2'h2);
    rs(1'b0);
    repeat (4) t(8'hf2, 5'h00, 1'b1, 2'h1);
    cmp(fail_count, 3'h4);
    cmp(attempts_exhausted_flag, 1'b0);
    t(8'hf2, 5'h00, 1'b1, 2'h1);
    cmp(attempts_exhausted_flag, 1'b1);
    t(8'hf2, OK, 1'b1, 2'h1);
    t(8'hf4, OK, 1'b1, 2'h1);
    rs(1'b0);
    cmp(attempts_exhausted_flag, 1'b0);
    cmp(fail_count, 3'h0);
    t(8'hf4, OK, 1'b0, 2'h0);
    cmp(erase_user_data, 1'b1);
    cmp(user_pw_set, 1'b0);
    t(8'hf1, 5'h01, 1'b0, 2'h0);
    cmp(level_max, 1'b1);
    rs(1'b0);
    t(8'hf2, MOK, 1'b1, 2'h1);
    cmp(fail_count, 3'h0);
    t(8'hf4, MOK, 1'b0, 2'h0);
    cmp(erase_user_data, 1'b1);
    rs(1'b1);
    cmp(sec_mode, 2'h0);
    cmp(master_rev_code, 16'hfffe);
    complete_run;
  end
endmodule
bind dsl_lock_fsm dsl_chk chk_u (.*);
